//--- logic/memory_bus_priority_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module memory_bus_priority_arbiter
   import bus_arb_pkg::*;
#(
   parameter frame_t FRAME = FRAME_DMA
)
(
   input wire logic clk,
   input wire logic rst,
   input wire prog_req_t fetch,
   input wire prog_req_t prog_rd,
   input wire prog_req_t prog_wr,
   input wire data_req_t data_rd,
   input wire data_req_t data_wr,
   input wire data_req_t dma,
   input wire logic periph_rdy,
   input wire logic [DW-1:0] periph_rdata,
   output logic [NUM_REQ-1:0] held,
   output logic [NUM_REQ-1:0] done,
   output logic [NUM_REQ-1:0] refused,
   output logic [DW-1:0] rdata,
   output periph_t periph
);

   // ----------------------------------------
   // Size and requester checks
   // ----------------------------------------
   function automatic logic refuse_fn(input int idx, input logic wide);
      logic bad;
      bad = 1'b0;
      if (FRAME == FRAME_W16 && wide)
         bad = 1'b1;
      if (idx == IDX_DMA && FRAME != FRAME_DMA)
         bad = 1'b1;
      return bad;
   endfunction : refuse_fn

   // Fixed priority encoder; the DMA slot sits below every processor slot
   function automatic logic [2:0] pick_fn(input logic [NUM_REQ-1:0] hv);
      logic [2:0] w;
      w = 3'(IDX_DMA);
      // write slots never tie, so plain order suffices
      // read and fetch never tie either
      if (hv[IDX_DWR])
         w = 3'(IDX_DWR);
      else if (hv[IDX_PWR])
         w = 3'(IDX_PWR);
      else if (hv[IDX_DRD])
         w = 3'(IDX_DRD);
      else if (hv[IDX_PRD])
         w = 3'(IDX_PRD);
      else if (hv[IDX_FETCH])
         w = 3'(IDX_FETCH);
      return w;
   endfunction : pick_fn

   // ----------------------------------------
   // Normalised requests
   // ----------------------------------------
   data_req_t in_req [NUM_REQ];
   data_req_t hold_q [NUM_REQ];
   logic [NUM_REQ-1:0] hold_v_q;
   arb_state_t state_q;
   arb_state_t state_d;
   logic [2:0] owner_q;
   logic [2:0] win;
   logic grant_go;
   logic conflict;

   // program buses widen their 22-bit address, always a full word
   // data buses pass their 32-bit address unchanged
   always_comb
   begin
      in_req[IDX_FETCH] = '{fetch.valid, 1'b0, 1'b1, DATA_AW'(fetch.addr), fetch.data};
      in_req[IDX_PRD] = '{prog_rd.valid, 1'b0, 1'b1, DATA_AW'(prog_rd.addr), prog_rd.data};
      in_req[IDX_PWR] = '{prog_wr.valid, 1'b1, 1'b1, DATA_AW'(prog_wr.addr), prog_wr.data};
      in_req[IDX_DRD] = '{data_rd.valid, 1'b0, data_rd.wide, data_rd.addr, data_rd.data};
      in_req[IDX_DWR] = '{data_wr.valid, 1'b1, data_wr.wide, data_wr.addr, data_wr.data};
      in_req[IDX_DMA] = dma;
   end

   // ----------------------------------------
   // Holding slots, one per bus
   // ----------------------------------------
   // every bus owns a slot, so all three are taken in one cycle, except on the narrow flavour, which refuses every fetch
   for (genvar i = 0; i < NUM_REQ; i++)
   begin : g_slot
      logic take;
      logic clear;
      assign take = in_req[i].valid && !hold_v_q[i] && !refuse_fn(i, in_req[i].wide);
      assign clear = grant_go && (win == 3'(i));

      // slot frozen until its grant; a new capture only while empty
      always_ff @(posedge clk)
      begin
         if (rst)
         begin
            hold_v_q[i] <= 1'b0;
            hold_q[i] <= '0;
         end
         else if (take)
         begin
            hold_v_q[i] <= 1'b1;
            hold_q[i] <= in_req[i];
         end
         else if (clear)
         begin
            hold_v_q[i] <= 1'b0;
         end
      end

      // Refusal is a pulse; the master must not retry the same size
      always_ff @(posedge clk)
      begin
         if (rst)
            refused[i] <= 1'b0;
         else
            refused[i] <= in_req[i].valid && !hold_v_q[i] && refuse_fn(i, in_req[i].wide);
      end

      pend_hold_a: assert property (@(posedge clk) disable iff (rst)
         hold_v_q[i] && !clear |=> hold_v_q[i] && $stable(hold_q[i]))
         else $error("pending request changed before grant");
   end

   assign held = hold_v_q;

   // ----------------------------------------
   // Grant sequencing
   // ----------------------------------------
   assign win = pick_fn(hold_v_q);
   // processor and DMA meeting at once
   assign conflict = hold_v_q[IDX_DMA] && (|hold_v_q[IDX_DWR:IDX_FETCH]);
   assign grant_go = (state_q == ST_STALL) || (state_q == ST_IDLE && |hold_v_q && !conflict);

   // one sequencer resolves the requests of all six slots
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
         begin
            // grant at once; a DMA clash first spends one stall cycle
            if (conflict)
               state_d = ST_STALL;
            else if (|hold_v_q)
               state_d = ST_BUSY;
         end
         ST_STALL:
            state_d = ST_BUSY;
         ST_BUSY:
         begin
            if (periph_rdy)
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // Arbiter state
   always_ff @(posedge clk)
   begin
      if (rst)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // ----------------------------------------
   // Peripheral side of the bridge
   // ----------------------------------------
   // low 16 address bits, full data path, control bits
   // a wide word leaves as one access
   // both sizes pass unless the narrow flavour refused them
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         periph <= '0;
         owner_q <= OWNER_RST;
      end
      else if (grant_go)
      begin
         periph.valid <= 1'b1;
         periph.write <= hold_q[win].write;
         periph.wide <= hold_q[win].wide;
         periph.addr <= hold_q[win].addr[PERIPH_AW-1:0];
         periph.wdata <= hold_q[win].data;
         owner_q <= win;
      end
      else if (state_q == ST_BUSY && periph_rdy)
      begin
         periph.valid <= 1'b0;
      end
   end

   // Completion pulse to the owner and read data, held until the next completion
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         done <= '0;
         rdata <= '0;
      end
      else
      begin
         done <= '0;
         if (state_q == ST_BUSY && periph_rdy)
         begin
            done[owner_q] <= 1'b1;
            rdata <= periph_rdata;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // data write wins
   prio_dwr_a: assert property (@(posedge clk) disable iff (rst)
      grant_go && hold_v_q[IDX_DWR] |=> owner_q == 3'(IDX_DWR))
      else $error("data write lost arbitration");

   // data read over program read and fetch
   prio_drd_a: assert property (@(posedge clk) disable iff (rst)
      grant_go && hold_v_q[IDX_DRD] && !hold_v_q[IDX_DWR] && !hold_v_q[IDX_PWR]
      |=> owner_q == 3'(IDX_DRD))
      else $error("data read not served ahead of program reads");

   // exactly one stall cycle on a DMA clash
   dma_stall_a: assert property (@(posedge clk) disable iff (rst)
      state_q == ST_IDLE && conflict |=> state_q == ST_STALL ##1 state_q == ST_BUSY)
      else $error("DMA clash not delayed by one cycle");

   // narrow flavour never issues a word
   narrow_only_a: assert property (@(posedge clk) disable iff (rst)
      periph.valid |-> !(FRAME == FRAME_W16 && periph.wide))
      else $error("wide access on narrow peripheral bus");

   // DMA only granted on its flavour
   dma_gate_a: assert property (@(posedge clk) disable iff (rst)
      periph.valid && owner_q == 3'(IDX_DMA) |-> FRAME == FRAME_DMA)
      else $error("DMA granted on a bus without DMA access");

   // address taken from the winner's low bits
   addr_map_a: assert property (@(posedge clk) disable iff (rst)
      grant_go |=> periph.valid && periph.addr == $past(hold_q[win].addr[PERIPH_AW-1:0]))
      else $error("peripheral address not the winner's");

   // whole word in one access, completion the next cycle after ready
   one_beat_a: assert property (@(posedge clk) disable iff (rst)
      state_q == ST_BUSY && periph_rdy |=> $onehot(done) && state_q == ST_IDLE && !periph.valid)
      else $error("word transfer not completed in one access");

   // simultaneous fetch, read and write all captured together
   par_take_a: assert property (@(posedge clk) disable iff (rst)
      fetch.valid && data_rd.valid && data_wr.valid && !hold_v_q[IDX_FETCH]
      && !hold_v_q[IDX_DRD] && !hold_v_q[IDX_DWR] && FRAME != FRAME_W16
      |=> hold_v_q[IDX_FETCH] && hold_v_q[IDX_DRD] && hold_v_q[IDX_DWR])
      else $error("parallel buses not taken in one cycle");

endmodule : memory_bus_priority_arbiter
`default_nettype wire

//--- logic/bus_arb_pkg.sv
`default_nettype none
package bus_arb_pkg;
   // ----------------------------------------
   // Widths of the memory and peripheral buses
   // ----------------------------------------
   localparam int PROG_AW = 22;
   localparam int DATA_AW = 32;
   localparam int DW = 32;
   localparam int PERIPH_AW = 16;

   // ----------------------------------------
   // Requester slots, lowest index is served last among the processor slots
   // ----------------------------------------
   localparam int NUM_REQ = 6;
   localparam int IDX_FETCH = 0;
   localparam int IDX_PRD = 1;
   localparam int IDX_DRD = 2;
   localparam int IDX_PWR = 3;
   localparam int IDX_DWR = 4;
   localparam int IDX_DMA = 5;
   localparam logic [2:0] OWNER_RST = 3'h0;

   // ----------------------------------------
   // Peripheral bus flavours and arbiter states
   // ----------------------------------------
   typedef enum logic [1:0] {FRAME_W16 = 2'h0, FRAME_W32 = 2'h1, FRAME_DMA = 2'h2} frame_t;
   // Idle and busy alternate on the usual path, so they differ in one bit only
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_BUSY = 2'h1, ST_STALL = 2'h3} arb_state_t;

   // ----------------------------------------
   // Bus carriers
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      logic [PROG_AW-1:0] addr;
      logic [DW-1:0] data;
   } prog_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic wide;
      logic [DATA_AW-1:0] addr;
      logic [DW-1:0] data;
   } data_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic wide;
      logic [PERIPH_AW-1:0] addr;
      logic [DW-1:0] wdata;
   } periph_t;
endpackage : bus_arb_pkg
`default_nettype wire

//--- tb/periph_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module periph_target_model
   import bus_arb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire periph_t periph,
   input wire logic [3:0] wait_n,
   output logic periph_rdy,
   output logic [DW-1:0] periph_rdata
);
   // ----------------------------------------
   // Target with a settable number of wait cycles
   // ----------------------------------------
   logic [3:0] cnt_q;
   logic [DW-1:0] junk_q;

   // Wait counter restarts for every access
   always @(posedge clk)
   begin
      if (rst || !periph.valid || periph_rdy)
         cnt_q <= 4'h0;
      else
         cnt_q <= cnt_q + 4'h1;
   end

   // Junk changes every cycle so a stale sample can never look right
   always @(posedge clk)
   begin
      if (rst)
         junk_q <= 32'h1357_9BDF;
      else
         junk_q <= junk_q + 32'h9E37_79B9;
   end

   assign periph_rdy = periph.valid && (cnt_q == wait_n);
   // Read data is the address and its inverse, only while ready
   assign periph_rdata = periph_rdy ? {periph.addr, ~periph.addr} : junk_q;
endmodule : periph_target_model
`default_nettype wire

//--- tb/memory_bus_priority_arbiter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module memory_bus_priority_arbiter_tb_top import bus_arb_pkg::*;;
   // ----------------------------------------
   // Stimulus, design and target
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   prog_req_t fetch = '0, prog_rd = '0, prog_wr = '0;
   data_req_t data_rd = '0, data_wr = '0, dma = '0;
   logic [3:0] wait_n = 4'h0;
   logic periph_rdy;
   logic [DW-1:0] periph_rdata, rdata;
   logic [NUM_REQ-1:0] held, done, refused, w16_held, w16_done, w16_ref, w32_ref;
   periph_t periph, w16_periph, w32_periph, last_p;
   int err_total = 0;
   int cmp_count = 0;
   int order_q[$];
   int lat;

   always #12.5 clk = ~clk;

   memory_bus_priority_arbiter #(.FRAME(FRAME_DMA)) memory_bus_priority_arbiter_inst (
      .clk(clk), .rst(rst), .fetch(fetch), .prog_rd(prog_rd), .prog_wr(prog_wr),
      .data_rd(data_rd), .data_wr(data_wr), .dma(dma), .periph_rdy(periph_rdy),
      .periph_rdata(periph_rdata), .held(held), .done(done), .refused(refused),
      .rdata(rdata), .periph(periph));
   // Narrow flavour sees the same requests; its target answers at once
   memory_bus_priority_arbiter #(.FRAME(FRAME_W16)) memory_bus_priority_arbiter_inst2 (
      .clk(clk), .rst(rst), .fetch(fetch), .prog_rd(prog_rd), .prog_wr(prog_wr),
      .data_rd(data_rd), .data_wr(data_wr), .dma(dma), .periph_rdy(w16_periph.valid),
      .periph_rdata(32'h0000_0000), .held(w16_held), .done(w16_done), .refused(w16_ref),
      .rdata(), .periph(w16_periph));
   // Wide flavour without DMA access; its target also answers at once
   memory_bus_priority_arbiter #(.FRAME(FRAME_W32)) memory_bus_priority_arbiter_inst3 (
      .clk(clk), .rst(rst), .fetch(fetch), .prog_rd(prog_rd), .prog_wr(prog_wr),
      .data_rd(data_rd), .data_wr(data_wr), .dma(dma), .periph_rdy(w32_periph.valid),
      .periph_rdata(32'h0000_0000), .held(), .done(), .refused(w32_ref),
      .rdata(), .periph(w32_periph));
   periph_target_model periph_target_model_inst (.clk(clk), .rst(rst), .periph(periph),
      .wait_n(wait_n), .periph_rdy(periph_rdy), .periph_rdata(periph_rdata));

   // Record the accepted access and the order of completions mid-cycle,
   // where they are settled and clear of the edge on which tasks act
   always @(negedge clk)
   begin
      if (periph.valid && periph_rdy)
         last_p = periph;
      for (int i = 0; i < NUM_REQ; i++)
         if (done[i] === 1'b1)
            order_q.push_back(i);
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Requests are shown for exactly one edge, the edge that takes them
   task automatic take;
      @(posedge clk);
      fetch.valid <= 1'b0;
      prog_rd.valid <= 1'b0;
      prog_wr.valid <= 1'b0;
      data_rd.valid <= 1'b0;
      data_wr.valid <= 1'b0;
      dma.valid <= 1'b0;
   endtask : take

   // Bounded so a lost completion cannot hang the run
   task automatic wait_for(input int idx);
      // The edge that takes the request counts as the first cycle
      lat = 1;
      do
      begin
         @(posedge clk);
         #1;
         lat++;
      end while (done[idx] !== 1'b1 && lat < 60);
      chk("done seen", 1, done[idx]);
   endtask : wait_for

   task automatic t_write;
      @(posedge clk);
      data_wr <= '{1'b1, 1'b0, 1'b1, 32'h1234_BEEF, 32'hCAFE_F00D};
      take();
      wait_for(IDX_DWR);
      chk("latency", 3, lat);
      chk("write", 1, last_p.write);
      chk("addr", 32'h0000_BEEF, last_p.addr);
      chk("wdata", 32'hCAFE_F00D, last_p.wdata);
      chk("wide", 1, last_p.wide);
   endtask : t_write

   // Fetch without program read, program write without data write
   task automatic t_prio;
      @(posedge clk);
      order_q.delete();
      data_wr <= '{1'b1, 1'b1, 1'b1, 32'h0000_1110, 32'h0000_0001};
      data_rd <= '{1'b1, 1'b0, 1'b1, 32'h0000_2220, 32'h0000_0000};
      fetch <= '{1'b1, 22'h3_3330, 32'h0000_0000};
      take();
      #1;
      chk("held", 6'h15, held);
      wait_for(IDX_FETCH);
      chk("first", IDX_DWR, order_q[0]);
      chk("second", IDX_DRD, order_q[1]);
      chk("fetch addr", 32'h0000_3330, last_p.addr);
      @(posedge clk);
      order_q.delete();
      prog_wr <= '{1'b1, 22'h0_4440, 32'h0000_0005};
      prog_rd <= '{1'b1, 22'h0_5550, 32'h0000_0000};
      take();
      wait_for(IDX_PRD);
      chk("pwr first", IDX_PWR, order_q[0]);
      // Let the last completion be logged before counting
      @(posedge clk);
      #1;
      chk("count", 2, order_q.size());
   endtask : t_prio

   task automatic t_dma;
      @(posedge clk);
      order_q.delete();
      dma <= '{1'b1, 1'b1, 1'b1, 32'h0000_6660, 32'h0000_0007};
      data_rd <= '{1'b1, 1'b0, 1'b1, 32'h0000_7770, 32'h0000_0000};
      take();
      wait_for(IDX_DRD);
      chk("clash latency", 4, lat);
      wait_for(IDX_DMA);
      chk("dma write", 1, last_p.write);
      chk("dma addr", 32'h0000_6660, last_p.addr);
   endtask : t_dma

   task automatic t_read;
      @(posedge clk);
      wait_n <= 4'h3;
      prog_rd <= '{1'b1, 22'h2_A5C3, 32'h0000_0000};
      take();
      wait_for(IDX_PRD);
      chk("rdata", 32'hA5C3_5A3C, rdata);
      chk("slow latency", 6, lat);
      @(posedge clk);
      wait_n <= 4'h0;
      data_rd <= '{1'b1, 1'b0, 1'b0, 32'h0000_0042, 32'h0000_0000};
      take();
      wait_for(IDX_DRD);
      chk("narrow", 0, last_p.wide);
      chk("narrow rdata", 32'h0042_FFBD, rdata);
   endtask : t_read

   task automatic t_refuse;
      @(posedge clk);
      data_wr <= '{1'b1, 1'b1, 1'b1, 32'h0000_0810, 32'h0000_0009};
      dma <= '{1'b1, 1'b0, 1'b1, 32'h0000_0820, 32'h0000_0000};
      take();
      #1;
      chk("refused", 6'h30, w16_ref);
      chk("w32 refused", 6'h20, w32_ref);
      chk("dma frame refused", 0, refused);
      wait_for(IDX_DMA);
      @(posedge clk);
      data_wr <= '{1'b1, 1'b1, 1'b0, 32'h0000_0830, 32'h0000_000A};
      take();
      #1;
      chk("narrow held", 6'h10, w16_held);
      @(posedge clk);
      #1;
      chk("narrow access", 32'h0002_0830, {w16_periph.valid, w16_periph.wide, w16_periph.addr});
      wait_for(IDX_DWR);
      chk("narrow done", 6'h10, w16_done);
   endtask : t_refuse

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   // Whole sequence needs well under a thousand cycles
   initial
   begin
      #50000;
      err_total++;
      give_verdict();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_write();
      t_prio();
      t_dma();
      t_read();
      t_refuse();
      give_verdict();
   end
endmodule : memory_bus_priority_arbiter_tb_top
`default_nettype wire
